// ==== design/rtwu_regs.svh ====
`ifndef RTWU_REGS_SVH
`define RTWU_REGS_SVH
`define RTWU_CLK_MHZ 50
`define RTWU_DRT_LONG_US 18000
`define RTWU_DRT_SHORT_US 10
`define RTWU_WDT_PERIOD_US 18000
`define RTWU_OFF_STATUS 32'h0000_0000
`define RTWU_OFF_OPTION 32'h0000_0004
`define RTWU_OFF_CONFIG 32'h0000_0008
`define RTWU_STAT_PCW 7
`define RTWU_STAT_TO_N 4
`define RTWU_STAT_PD_N 3
`define RTWU_OPT_WAKE_EN_N 7
`define RTWU_OPT_PSA 3
`define RTWU_OPT_RATE_HI 2
`define RTWU_OPT_RESET 8'hff
`define RTWU_CFG_PIN_EN 0
`define RTWU_CFG_WDT_EN 1
`define RTWU_CFG_OSC_LO 2
`define RTWU_CFG_OSC_HI 4
`define RTWU_CFG_RESET 5'h03
`endif

// ==== design/rtwu_pkg.sv ====
`default_nettype none
package rtwu_pkg;
	typedef enum logic [2:0] {
		INTERNAL_RC_OSC_MODE = 3'b000,
		EXTERNAL_RC_OSC_MODE = 3'b001,
		STANDARD_CRYSTAL_MODE = 3'b010,
		HIGH_SPEED_CRYSTAL_MODE = 3'b011,
		LOW_POWER_CRYSTAL_MODE = 3'b100,
		EXTERNAL_CLOCK_MODE = 3'b101
	} rtwu_osc_mode_t;
	typedef logic [1:0] rtwu_resp_t;
	localparam rtwu_resp_t RTWU_RESP_OKAY = 2'h0;
	localparam rtwu_resp_t RTWU_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== design/rtwu_wdt_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface rtwu_wdt_if;
	logic clear;
	logic enable;
	logic assign_sel;
	logic [2:0] rate;
	logic expire;
	modport ctrl (output clear, enable, assign_sel, rate, input expire);
	modport wdt (input clear, enable, assign_sel, rate, output expire);
endinterface
`default_nettype wire

// ==== design/rtwu_watchdog.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtwu_regs.svh"
module rtwu_watchdog #(
	parameter int unsigned PERIOD_CYC = `RTWU_WDT_PERIOD_US * `RTWU_CLK_MHZ
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	rtwu_wdt_if.wdt wd
);
	logic [31:0] base_cnt;
	logic [6:0] pre_cnt;
	logic expire;
	logic [31:0] since_clear;
	wire base_wrap = (base_cnt == PERIOD_CYC - 1);
	wire [6:0] pre_last = wd.assign_sel ? ((7'h01 << wd.rate) - 7'h01) : 7'h00;
	wire next_expire = wd.enable && !wd.clear && base_wrap && (pre_cnt >= pre_last);
	assign wd.expire = expire;

	// Free running counter, cleared by instruction or wake
	always_ff @(posedge SYS_CLK) begin
		if (RST || wd.clear || !wd.enable || next_expire) begin
			base_cnt <= 32'h0;
			pre_cnt <= 7'h00;
		end else if (base_wrap) begin
			base_cnt <= 32'h0;
			pre_cnt <= pre_cnt + 7'h01;
		end else begin
			base_cnt <= base_cnt + 32'h1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			expire <= 1'b0;
		end else begin
			expire <= next_expire;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST || wd.clear || expire) begin
			since_clear <= 32'h0;
		end else if (since_clear != 32'hffff_ffff) begin
			since_clear <= since_clear + 32'h1;
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	property p_wdt_off;
		!wd.enable |=> !expire;
	endproperty
	a_wdt_off: assert property (p_wdt_off) else $error("watchdog fired while disabled");

	property p_wdt_min_period;
		expire && !$past(wd.assign_sel) |-> $past(since_clear) >= PERIOD_CYC - 1;
	endproperty
	a_wdt_min_period: assert property (p_wdt_min_period) else $error("watchdog fired early");

	property p_wdt_clear;
		wd.clear |=> !expire;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog fired after clear");
endmodule
`default_nettype wire

// ==== design/rtwu_top.sv ====
// Contract
// - Reset pin fuse at one enables pin reset; programmed makes pin plain input.
// - Power-up sets reset latch, clears timer; timer counts once pin high; expiry releases.
// - Reset timer runs from its own oscillator; core held while it counts; here it counts SYS_CLK cycles.
// - Delay 18 ms after power-up or crystal modes, else 10 us.
// - Watchdog expiry during sleep also runs the reset timer delay.
// - Watchdog runs from its own oscillator and keeps counting during sleep; here it is clocked by SYS_CLK.
// - Watchdog expiry causes full device reset, awake or asleep.
// - A watchdog reset clears the active-low time-out flag, status bit 4, unless a pin reset comes in the same cycle.
// - Watchdog enable fuse at zero disables watchdog permanently; here a config register write setting bit 1 re-enables it.
// - Base watchdog period 18 ms, optionally stretched by prescaler up to 1:128.
// - Watchdog clear instruction resets counter and assigned prescaler.
// - Sleep instruction resets counter and assigned prescaler.
// - Wake flags: watchdog 0,0,0; pin reset 0,1,0; pin change 1,1,0.
// - Awake flags: power-up 0,1,1; watchdog 0,0,u; pin reset 0,u,u.
// - Flags hold until a reset or sleep instruction; pin pulse alone changes none beyond that.
// - Power-on, reset pin, watchdog and pin-change wake all drive chip reset.
// - Power-down flag, status bit 3, set on power-up, cleared by sleep.
// - Watchdog cleared whenever the device wakes, whatever the cause.
// - In sleep, wake when monitored pins differ from last port read value.
`timescale 1ns/1ps
`default_nettype none
`include "rtwu_regs.svh"
module rtwu_top #(
	parameter int unsigned DRT_LONG_CYC = `RTWU_DRT_LONG_US * `RTWU_CLK_MHZ,
	parameter int unsigned WDT_PERIOD_CYC = `RTWU_WDT_PERIOD_US * `RTWU_CLK_MHZ,
	parameter int unsigned PORT_W = 4,
	parameter logic [PORT_W-1:0] WAKE_MASK = 4'hf
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic EXTERNAL_RESET_PIN_N,
	input wire logic [PORT_W-1:0] PORT_PINS,
	input wire logic PORT_READ,
	input wire logic WATCHDOG_CLEAR_INSTR,
	input wire logic SLEEP_INSTR,
	output logic CHIP_RESET,
	output logic SLEEPING,
	input wire logic [31:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [31:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	localparam int unsigned DRT_SHORT_CYC = `RTWU_DRT_SHORT_US * `RTWU_CLK_MHZ;

	logic pin_meta, pin_sync;
	logic [PORT_W-1:0] port_meta, port_sync, port_capt;
	logic pcw_flag, to_n, pd_n, drt_long;
	logic [31:0] drt_cnt;
	logic [7:0] option;
	logic [4:0] config_fuse;
	logic aw_full, w_full;
	logic [31:0] aw_addr, w_data;
	logic w_lane0;

	rtwu_wdt_if wd_bus();

	// Two-flop synchronisers for pins
	always_ff @(posedge SYS_CLK) begin
		pin_meta <= EXTERNAL_RESET_PIN_N;
		pin_sync <= pin_meta;
		port_meta <= PORT_PINS;
		port_sync <= port_meta;
	end

	wire pin_en = config_fuse[`RTWU_CFG_PIN_EN];
	wire pin_high = !pin_en || pin_sync;
	wire pin_rst_evt = pin_en && !pin_sync;
	wire wdt_evt = wd_bus.expire;
	wire pcw_evt = SLEEPING && !CHIP_RESET && !option[`RTWU_OPT_WAKE_EN_N]
		&& ((port_sync & WAKE_MASK) != (port_capt & WAKE_MASK));
	wire any_evt = pin_rst_evt || wdt_evt || pcw_evt;
	wire sleep_go = SLEEP_INSTR && !CHIP_RESET && !SLEEPING;
	wire [2:0] osc = config_fuse[`RTWU_CFG_OSC_HI:`RTWU_CFG_OSC_LO];
	wire crystal = (osc == rtwu_pkg::STANDARD_CRYSTAL_MODE)
		|| (osc == rtwu_pkg::HIGH_SPEED_CRYSTAL_MODE)
		|| (osc == rtwu_pkg::LOW_POWER_CRYSTAL_MODE);
	wire [31:0] drt_last = drt_long ? DRT_LONG_CYC - 1 : DRT_SHORT_CYC - 1;

	assign wd_bus.clear = any_evt || sleep_go
		|| (WATCHDOG_CLEAR_INSTR && !CHIP_RESET);
	assign wd_bus.enable = config_fuse[`RTWU_CFG_WDT_EN];
	assign wd_bus.assign_sel = option[`RTWU_OPT_PSA];
	assign wd_bus.rate = option[`RTWU_OPT_RATE_HI:0];

	rtwu_watchdog #(.PERIOD_CYC(WDT_PERIOD_CYC)) u_wdt (
		.SYS_CLK(SYS_CLK),
		.RST(RST),
		.wd(wd_bus)
	);

	// Register decode
	wire do_wr = aw_full && w_full && !BVALID;
	wire wr_opt = do_wr && (aw_addr == `RTWU_OFF_OPTION) && w_lane0;
	wire wr_cfg = do_wr && (aw_addr == `RTWU_OFF_CONFIG) && w_lane0;
	wire wr_hit = (aw_addr == `RTWU_OFF_OPTION) || (aw_addr == `RTWU_OFF_CONFIG);
	wire rd_stat = (ARADDR == `RTWU_OFF_STATUS);
	wire rd_cfg = (ARADDR == `RTWU_OFF_CONFIG);
	wire rd_opt = (ARADDR == `RTWU_OFF_OPTION);
	wire [31:0] stat_word = {24'h0, pcw_flag, 2'h0, to_n, pd_n, 3'h0};
	wire [31:0] rd_word = rd_stat ? stat_word : (rd_cfg ? {27'h0, config_fuse} : 32'h0);

	// Reset latch, reset timer and cause flags
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			CHIP_RESET <= 1'b1;
			drt_cnt <= 32'h0;
			drt_long <= 1'b1;
			SLEEPING <= 1'b0;
			pcw_flag <= 1'b0;
			to_n <= 1'b1;
			pd_n <= 1'b1;
			option <= `RTWU_OPT_RESET;
			config_fuse <= `RTWU_CFG_RESET;
		end else begin
			if (wr_cfg) begin
				config_fuse <= w_data[4:0];
			end
			if (any_evt) begin
				CHIP_RESET <= 1'b1;
				drt_cnt <= 32'h0;
				drt_long <= crystal || (CHIP_RESET && drt_long);
				SLEEPING <= 1'b0;
				option <= `RTWU_OPT_RESET;
				if (pin_rst_evt) begin
					pcw_flag <= 1'b0;
					if (SLEEPING) begin
						to_n <= 1'b1;
						pd_n <= 1'b0;
					end
				end else if (wdt_evt) begin
					pcw_flag <= 1'b0;
					to_n <= 1'b0;
					if (SLEEPING) begin
						pd_n <= 1'b0;
					end
				end else begin
					pcw_flag <= 1'b1;
					to_n <= 1'b1;
					pd_n <= 1'b0;
				end
			end else if (CHIP_RESET) begin
				if (pin_high) begin
					if (drt_cnt == drt_last) begin
						CHIP_RESET <= 1'b0;
					end else begin
						drt_cnt <= drt_cnt + 32'h1;
					end
				end
			end else begin
				if (wr_opt) begin
					option <= w_data[7:0];
				end
				if (sleep_go) begin
					SLEEPING <= 1'b1;
					pd_n <= 1'b0;
					to_n <= 1'b1;
				end
			end
		end
	end

	// Port value captured at each read
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			port_capt <= '0;
		end else if (PORT_READ) begin
			port_capt <= port_sync;
		end
	end

	// AXI4-Lite write channel
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 32'h0;
			w_data <= 32'h0;
			w_lane0 <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= rtwu_pkg::RTWU_RESP_OKAY;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_full <= 1'b1;
				aw_addr <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_full <= 1'b1;
				w_data <= WDATA;
				w_lane0 <= WSTRB[0];
			end
			if (do_wr) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= wr_hit ? rtwu_pkg::RTWU_RESP_OKAY : rtwu_pkg::RTWU_RESP_SLVERR;
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	assign AWREADY = !aw_full && !BVALID;
	assign WREADY = !w_full && !BVALID;
	assign ARREADY = !RVALID;

	// AXI4-Lite read channel
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			RVALID <= 1'b0;
			RDATA <= 32'h0;
			RRESP <= rtwu_pkg::RTWU_RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			RVALID <= 1'b1;
			RDATA <= rd_word;
			RRESP <= (rd_stat || rd_cfg || rd_opt) ? rtwu_pkg::RTWU_RESP_OKAY
				: rtwu_pkg::RTWU_RESP_SLVERR;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	property p_por_flags;
		$past(RST) |-> CHIP_RESET && to_n && pd_n && !pcw_flag;
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("power-up flags wrong");

	property p_pin_reset;
		pin_rst_evt |=> CHIP_RESET ##1 CHIP_RESET;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin low did not reset");

	property p_held_low;
		CHIP_RESET && !pin_high |=> CHIP_RESET && drt_cnt == 32'h0;
	endproperty
	a_held_low: assert property (p_held_low) else $error("timer ran with pin low");

	property p_release;
		$fell(CHIP_RESET) |-> $past(drt_cnt) == $past(drt_last) && $past(pin_high);
	endproperty
	a_release: assert property (p_release) else $error("reset released early");

	property p_wdt_flag;
		wdt_evt && !pin_rst_evt |=> !to_n && !pcw_flag && CHIP_RESET;
	endproperty
	a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not cleared");

	property p_sleep_pd;
		sleep_go && !any_evt |=> SLEEPING && !pd_n && to_n;
	endproperty
	a_sleep_pd: assert property (p_sleep_pd) else $error("sleep flags wrong");

	property p_pcw_wake;
		pcw_evt && !pin_rst_evt && !wdt_evt |=> pcw_flag && to_n && !pd_n && !SLEEPING;
	endproperty
	a_pcw_wake: assert property (p_pcw_wake) else $error("pin change wake flags wrong");

	property p_long_kept;
		CHIP_RESET && drt_long |=> drt_long;
	endproperty
	a_long_kept: assert property (p_long_kept) else $error("long delay cut short");

	property p_short_delay;
		any_evt && !CHIP_RESET && !crystal |=> !drt_long;
	endproperty
	a_short_delay: assert property (p_short_delay) else $error("short delay not chosen");

	property p_pin_off;
		!pin_en && !wdt_evt && !pcw_evt && !CHIP_RESET |=> !CHIP_RESET;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("reset with pin disabled");

	property p_flags_hold;
		!any_evt && !sleep_go |=> $stable(to_n) && $stable(pd_n) && $stable(pcw_flag);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("cause flags changed");

	property p_reset_awake;
		CHIP_RESET |-> !SLEEPING;
	endproperty
	a_reset_awake: assert property (p_reset_awake) else $error("asleep during reset");

	property p_pcw_combo;
		pcw_flag |-> to_n && !pd_n;
	endproperty
	a_pcw_combo: assert property (p_pcw_combo) else $error("pin change flag combination");
endmodule
`default_nettype wire

// ==== tb/rtwu_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtwu_pin_model (
	input wire logic drive_low,
	output wire logic pin_n
);
	// Pull-up holds the pin high when released
	assign pin_n = drive_low ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ==== tb/reset_timer_watchdog_unit_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module reset_timer_watchdog_unit_test;
	logic clk = 0, rst = 1, pin_low = 1, prd = 0, slp = 0, clr = 0, seen = 0;
	logic [3:0] pins = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, q;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [1:0] r;
	wire logic pin_n, chip_rst, sleeping, awready, wready, bvalid, arready, rvalid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	int err_count = 0, checked = 0, n, pcw = 0, to_n = 1, pd_n = 1;
	rtwu_pin_model i_pin (.drive_low(pin_low), .pin_n(pin_n));
	rtwu_top #(.DRT_LONG_CYC(200), .WDT_PERIOD_CYC(700)) i_dut (.SYS_CLK(clk), .RST(rst),
		.EXTERNAL_RESET_PIN_N(pin_n), .PORT_PINS(pins), .PORT_READ(prd),
		.WATCHDOG_CLEAR_INSTR(clr), .SLEEP_INSTR(slp), .CHIP_RESET(chip_rst),
		.SLEEPING(sleeping), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
	initial forever #10 clk = ~clk;
	always @(negedge clk) if (chip_rst === 1'b1) seen = 1;
	function logic [31:0] st();
		return {24'h0, pcw[0], 2'b00, to_n[0], pd_n[0], 3'b000};
	endfunction
	task conclude;
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task axi(input bit w, input logic [31:0] a, input logic [31:0] d);
		int i;
		logic [4:0] f;
		@(posedge clk);
		if (w) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1;
			wvalid <= 1;
			bready <= 1;
		end else begin
			araddr <= a;
			arvalid <= 1;
			rready <= 1;
		end
		for (i = 0; i < 40; i++) begin
			@(negedge clk);
			if (!(awvalid | wvalid | bready | arvalid | rready)) break;
			f = {awready, wready, bvalid, arready, rvalid};
			if (bvalid && bready) r = bresp;
			if (rvalid && rready) begin
				q = rdata;
				r = rresp;
			end
			@(posedge clk);
			if (f[4]) awvalid <= 0;
			if (f[3]) wvalid <= 0;
			if (f[2]) bready <= 0;
			if (f[1]) arvalid <= 0;
			if (f[0]) rready <= 0;
		end
		if (i >= 40) begin
			err_count++;
			$display("FAIL %0t bus timeout", $time);
			conclude;
		end
	endtask
	task rchk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
		axi(0, a, 0);
		chk({r, q}, {er, e});
	endtask
	task wchk(input logic [31:0] a, input logic [31:0] d);
		axi(1, a, d);
		chk(r, 0);
	endtask
	task wt(input logic v, input int lim);
		n = 0;
		@(negedge clk);
		while (chip_rst !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (chip_rst !== v) begin
			err_count++;
			$display("FAIL %0t chip reset wait timeout", $time);
			conclude;
		end
	endtask
	task pulse(input int w);
		@(posedge clk);
		case (w)
			0: prd <= 1;
			1: slp <= 1;
			default: clr <= 1;
		endcase
		@(posedge clk);
		{prd, slp, clr} <= 3'b000;
	endtask
	task pin_pulse(input int k);
		@(posedge clk);
		pin_low <= 1;
		repeat (k) @(posedge clk);
		pin_low <= 0;
	endtask
	initial begin
		n = $urandom(32'h4c557f77);
		pins = 4'($urandom);
		repeat (20) @(posedge clk);
		rst <= 0;
		rchk(0, st(), 0);
		rchk(4, 0, 0);
		rchk(32'h0c, 0, 2);
		axi(1, 32'h0c, 0);
		chk(r, 2);
		repeat (40) @(posedge clk);
		rchk(8, 32'h03, 0);
		chk(chip_rst, 1);
		@(posedge clk);
		pin_low <= 0;
		wt(0, 400);
		chk(n >= 198 && n <= 208, 1);
		wchk(4, 32'hf0);
		wchk(8, 32'h01);
		seen = 0;
		repeat (1500) @(posedge clk);
		chk(seen, 0);
		wchk(8, 32'h03);
		wt(1, 800);
		to_n = 0;
		wt(0, 600);
		pulse(2);
		chk(n >= 497 && n <= 503, 1);
		rchk(0, st(), 0);
		wchk(4, 32'hf0);
		seen = 0;
		repeat (6) begin
			repeat (400) @(posedge clk);
			pulse(2);
		end
		chk(seen, 0);
		pin_pulse(3);
		wt(1, 20);
		wt(0, 600);
		rchk(0, st(), 0);
		wchk(4, 32'h7f);
		pulse(0);
		pulse(1);
		pd_n = 0;
		@(negedge clk);
		chk(sleeping, 1);
		repeat (20) @(posedge clk);
		pins <= pins ^ 4'($urandom_range(14) + 1);
		wt(1, 20);
		pcw = 1;
		to_n = 1;
		wt(0, 600);
		rchk(0, st(), 0);
		wchk(4, 32'hf9);
		pulse(1);
		wt(1, 1600);
		chk(n >= 1390 && n <= 1410, 1);
		pcw = 0;
		to_n = 0;
		wt(0, 600);
		rchk(0, st(), 0);
		pulse(1);
		pin_pulse(3);
		wt(1, 20);
		to_n = 1;
		wt(0, 600);
		rchk(0, st(), 0);
		wchk(8, 32'h0b);
		rchk(8, 32'h0b, 0);
		pin_pulse(3);
		wt(1, 20);
		wt(0, 600);
		chk(n >= 198 && n <= 208, 1);
		rchk(0, st(), 0);
		wchk(8, 32'h02);
		seen = 0;
		pin_pulse(20);
		repeat (5) @(posedge clk);
		chk(seen, 0);
		conclude;
	end
endmodule
`default_nettype wire
